// ---- logic/pdmr_pkg.sv ----
// Shared constants and types for the pulse-density microphone receiver.
// Assumes a single 250 MHz clock domain and an Avalon-MM register bus.
package pdmr_pkg;
   // Register byte offsets
   localparam logic [11:0] OFS_START = 12'h000;
   localparam logic [11:0] OFS_STOP = 12'h004;
   localparam logic [11:0] OFS_EV_STARTED = 12'h100;
   localparam logic [11:0] OFS_EV_STOPPED = 12'h104;
   localparam logic [11:0] OFS_EV_END = 12'h108;
   localparam logic [11:0] OFS_INC = 12'h504;
   localparam logic [11:0] OFS_MODE = 12'h508;
   localparam logic [11:0] OFS_GAIN_L = 12'h518;
   localparam logic [11:0] OFS_GAIN_R = 12'h51c;
   localparam logic [11:0] OFS_RATIO = 12'h520;
   localparam logic [11:0] OFS_MCLK = 12'h54c;
   localparam logic [11:0] OFS_PTR = 12'h560;
   localparam logic [11:0] OFS_MAXCNT = 12'h564;
   // Field positions
   localparam int MODE_MONO_BIT = 0;
   localparam int MODE_SWAP_BIT = 1;
   // Reset values and gain code limit
   localparam logic [31:0] RST_INC = 32'h0800_0000;
   localparam logic [6:0] GAIN_DEF = 7'h28;
   localparam logic [6:0] GAIN_MAX = 7'h50;
   // Decimation ratios and filter output shifts
   localparam logic [6:0] RATIO_LO = 7'h40;
   localparam logic [6:0] RATIO_HI = 7'h50;
   localparam int SHIFT_LO = 3;
   localparam int SHIFT_HI = 4;
   // Clock generator: bit period is floor(2^20 * 2^12 / increment)
   localparam longint PCLK_HZ = 32000000;
   localparam logic [32:0] DIV_DIVIDEND = 33'h1_0000_0000;
   localparam logic [5:0] DIV_STEPS = 6'h21;
   // Gain code offset and output shift at octave zero
   localparam logic [6:0] GAIN_OFS = 7'h08;
   localparam int GAIN_SHIFT0 = 18;
   // Sequencer states
   typedef enum logic [1:0] {PDMR_IDLE, PDMR_RUN} pdmr_state_t;
   // Software configuration carried as one bundle
   typedef struct packed {
      logic [31:0] inc;
      logic mono;
      logic swap;
      logic r80;
      logic aclk;
      logic [6:0] gl;
      logic [6:0] gr;
      logic [31:0] ptr;
      logic [14:0] maxcnt;
   } pdmr_cfg_t;
   // One memory write request
   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] data;
      logic wr;
   } pdmr_dma_t;
endpackage : pdmr_pkg

// ---- logic/pdmr_top.sv ----
// Pulse-density microphone receiver: clock generator, two decimating
// channels with gain, word packing and a double-buffered memory writer.
// Assumes master clock ticks arrive as one-cycle pulses on the system
// clock and that memory is an Avalon-MM slave with waitrequest.
// Summary of operation
// - Bit clock from 32 MHz or audio tick
// - Bit period is floor(2^32 / increment) ticks
// - Increment changes apply without stopping clock
// - Left on falling, right on rising edge
// - Swap setting exchanges the two edges
// - Each channel decimated to 16-bit PCM
// - Decimation ratio selectable, 64 or 80
// - Per-channel gain, -20 to +20 dB
// - Gain code step is 0.5 dB
// - Stereo word {R,L}; mono two lefts
// - Samples stored little-endian
// - Buffer length counted in 16-bit samples
// - Pointer double-buffered, next buffer uses it
// - End event when buffer filled
// - Continue seamlessly at next pointer, started
// - Stop waits for current frame, then stopped
// - Stopped only after memory writes complete
// - End also raised on last write after stop
//
// The Avalon-MM interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ns
module pdmr_top #(
   parameter int IW = 24
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [11:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic peripheral_clock_32m_tick,
   input wire logic aclk_tick,
   output logic pdm_clk,
   input wire logic pdm_din,
   output logic [31:0] dma_address,
   output logic [31:0] dma_writedata,
   output logic dma_write,
   input wire logic dma_waitrequest
);
   // Byte-lane merge for partial writes
   function automatic logic [31:0] be_merge(input logic [31:0] o,
         input logic [31:0] n, input logic [3:0] be);
      logic [31:0] r;
      r = o;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[8*b +: 8] = n[8*b +: 8];
         end
      end
      return r;
   endfunction : be_merge

   // Clamp a wide signed value to 16 bits
   function automatic logic [15:0] sat16(input logic signed [39:0] v);
      if (v > 40'sd32767) begin
         return 16'h7fff;
      end else if (v < -40'sd32768) begin
         return 16'h8000;
      end
      return v[15:0];
   endfunction : sat16

   // Gain code to {octave, Q14 mantissa}; 12 codes make one octave
   function automatic logic [19:0] gain_f(input logic [6:0] g);
      logic [6:0] k;
      logic [3:0] r;
      logic [16:0] m;
      k = ((g > pdmr_pkg::GAIN_MAX) ? pdmr_pkg::GAIN_MAX : g)
          + pdmr_pkg::GAIN_OFS;
      r = 4'(k % 7'h0c);
      case (r)
         4'h0: m = 17'h04000;
         4'h1: m = 17'h043ce;
         4'h2: m = 17'h047d6;
         4'h3: m = 17'h04c1c;
         4'h4: m = 17'h050a3;
         4'h5: m = 17'h0556e;
         4'h6: m = 17'h05a82;
         4'h7: m = 17'h05fe4;
         4'h8: m = 17'h06598;
         4'h9: m = 17'h06ba2;
         4'ha: m = 17'h07209;
         default: m = 17'h078d1;
      endcase
      return {3'(k / 7'h0c), m};
   endfunction : gain_f

   // Bus slave state
   pdmr_pkg::pdmr_cfg_t cfg_r, cfg_nxt;
   logic [2:0] ev_r, ev_nxt;       // started, stopped, end flags
   logic [2:0] ev_set;             // hardware event pulses
   logic wait_r, wait_nxt;
   logic [31:0] rd_r, rd_nxt;
   logic acc, tsk_start, tsk_stop;

   // Register access: one wait cycle, then the access completes
   always_comb begin
      acc = (avs_read | avs_write) & ~wait_r;
      wait_nxt = ~((avs_read | avs_write) & wait_r);
      tsk_start = acc & avs_write & avs_writedata[0] &
                  (avs_address == pdmr_pkg::OFS_START);
      tsk_stop = acc & avs_write & avs_writedata[0] &
                 (avs_address == pdmr_pkg::OFS_STOP);
      cfg_nxt = cfg_r;
      ev_nxt = ev_r;
      // Clears only on a written zero; a same-cycle set still wins
      if (acc & avs_write & avs_writedata[0] == 1'b0) begin
         case (avs_address)
            pdmr_pkg::OFS_EV_STARTED: ev_nxt[0] = 1'b0;
            pdmr_pkg::OFS_EV_STOPPED: ev_nxt[1] = 1'b0;
            pdmr_pkg::OFS_EV_END: ev_nxt[2] = 1'b0;
            default: ;
         endcase
      end
      ev_nxt = ev_nxt | ev_set;
      if (acc & avs_write) begin
         case (avs_address)
            pdmr_pkg::OFS_INC:
               cfg_nxt.inc = be_merge(cfg_r.inc, avs_writedata,
                                      avs_byteenable);
            pdmr_pkg::OFS_MODE: begin
               cfg_nxt.mono = avs_writedata[pdmr_pkg::MODE_MONO_BIT];
               cfg_nxt.swap = avs_writedata[pdmr_pkg::MODE_SWAP_BIT];
            end
            pdmr_pkg::OFS_GAIN_L: cfg_nxt.gl = avs_writedata[6:0];
            pdmr_pkg::OFS_GAIN_R: cfg_nxt.gr = avs_writedata[6:0];
            pdmr_pkg::OFS_RATIO: cfg_nxt.r80 = avs_writedata[0];
            pdmr_pkg::OFS_MCLK: cfg_nxt.aclk = avs_writedata[0];
            // Shadow pointer, latched at buffer start
            pdmr_pkg::OFS_PTR:
               cfg_nxt.ptr = be_merge(cfg_r.ptr, avs_writedata,
                                      avs_byteenable);
            pdmr_pkg::OFS_MAXCNT: cfg_nxt.maxcnt = avs_writedata[14:0];
            default: ;
         endcase
      end
      // Read data prepared in the wait cycle; unmapped reads give zero
      case (avs_address)
         pdmr_pkg::OFS_EV_STARTED: rd_nxt = {31'h0, ev_r[0]};
         pdmr_pkg::OFS_EV_STOPPED: rd_nxt = {31'h0, ev_r[1]};
         pdmr_pkg::OFS_EV_END: rd_nxt = {31'h0, ev_r[2]};
         pdmr_pkg::OFS_INC: rd_nxt = cfg_r.inc;
         pdmr_pkg::OFS_MODE: rd_nxt = {30'h0, cfg_r.swap, cfg_r.mono};
         pdmr_pkg::OFS_GAIN_L: rd_nxt = {25'h0, cfg_r.gl};
         pdmr_pkg::OFS_GAIN_R: rd_nxt = {25'h0, cfg_r.gr};
         pdmr_pkg::OFS_RATIO: rd_nxt = {31'h0, cfg_r.r80};
         pdmr_pkg::OFS_MCLK: rd_nxt = {31'h0, cfg_r.aclk};
         pdmr_pkg::OFS_PTR: rd_nxt = cfg_r.ptr;
         pdmr_pkg::OFS_MAXCNT: rd_nxt = {17'h0, cfg_r.maxcnt};
         default: rd_nxt = 32'h0;
      endcase
      // Loaded only in a read's first cycle, held until the next read
      if (~(avs_read & wait_r)) begin
         rd_nxt = rd_r;
      end
   end

   // Bus registers
   always_ff @(posedge clock) begin
      if (rst) begin
         cfg_r <= '{inc: pdmr_pkg::RST_INC, gl: pdmr_pkg::GAIN_DEF,
                    gr: pdmr_pkg::GAIN_DEF, default: '0};
         ev_r <= 3'h0;
         wait_r <= 1'b1;
         rd_r <= 32'h0;
      end else begin
         cfg_r <= cfg_nxt;
         ev_r <= ev_nxt;
         wait_r <= wait_nxt;
         rd_r <= rd_nxt;
      end
   end
   assign avs_readdata = rd_r;
   assign avs_waitrequest = wait_r;

   // Period divider: recomputed whenever the increment moves
   logic [32:0] rem_r, rem_nxt, quo_r, quo_nxt, per_r, per_nxt;
   logic [31:0] dinc_r, dinc_nxt;
   logic [5:0] dstep_r, dstep_nxt;
   always_comb begin
      logic [32:0] t;
      t = 33'h0;
      rem_nxt = rem_r;
      quo_nxt = quo_r;
      per_nxt = per_r;
      dinc_nxt = dinc_r;
      dstep_nxt = dstep_r;
      if (dstep_r == 6'h0) begin
         if (dinc_r != cfg_r.inc) begin
            dinc_nxt = cfg_r.inc;
            dstep_nxt = pdmr_pkg::DIV_STEPS;
            rem_nxt = 33'h0;
            quo_nxt = 33'h0;
         end
      end else begin
         // Restoring division gives the floored period
         t = {rem_r[31:0], pdmr_pkg::DIV_DIVIDEND[dstep_r - 6'h1]};
         quo_nxt = {quo_r[31:0], t >= {1'b0, dinc_r}};
         rem_nxt = (t >= {1'b0, dinc_r}) ? t - {1'b0, dinc_r} : t;
         dstep_nxt = dstep_r - 6'h1;
         if (dstep_r == 6'h1) begin
            per_nxt = quo_nxt;
         end
      end
   end

   // Divider registers
   always_ff @(posedge clock) begin
      if (rst) begin
         rem_r <= 33'h0;
         quo_r <= 33'h0;
         per_r <= 33'h2;
         dinc_r <= 32'h0;
         dstep_r <= 6'h0;
      end else begin
         rem_r <= rem_nxt;
         quo_r <= quo_nxt;
         per_r <= per_nxt;
         dinc_r <= dinc_nxt;
         dstep_r <= dstep_nxt;
      end
   end

   // Bit clock generator
   pdmr_pkg::pdmr_state_t st_r, st_nxt;
   logic [32:0] cnt_r, cnt_nxt, pact_r, pact_nxt;
   logic clk_r, clk_nxt, tick, rise_ev, fall_ev;
   logic [1:0] smp_ev;
   always_comb begin
      // Source select between the two master ticks
      tick = cfg_r.aclk ? aclk_tick : peripheral_clock_32m_tick;
      cnt_nxt = cnt_r;
      pact_nxt = pact_r;
      clk_nxt = clk_r;
      rise_ev = 1'b0;
      fall_ev = 1'b0;
      // Idle holds the clock low and stops sampling
      if (st_r == pdmr_pkg::PDMR_IDLE) begin
         cnt_nxt = 33'h0;
         clk_nxt = 1'b0;
         pact_nxt = (per_r < 33'h2) ? 33'h2 : per_r;
      end else if (tick) begin
         cnt_nxt = cnt_r + 33'h1;
         if (cnt_r == (pact_r >> 1) - 33'h1) begin
            clk_nxt = 1'b1;
            rise_ev = 1'b1;
         end
         if (cnt_r >= pact_r - 33'h1) begin
            // New period taken at the period boundary
            cnt_nxt = 33'h0;
            clk_nxt = 1'b0;
            fall_ev = 1'b1;
            pact_nxt = (per_r < 33'h2) ? 33'h2 : per_r;
         end
      end
      smp_ev[0] = cfg_r.swap ? rise_ev : fall_ev;
      smp_ev[1] = cfg_r.swap ? fall_ev : rise_ev;
   end

   // Clock generator registers
   always_ff @(posedge clock) begin
      if (rst) begin
         cnt_r <= 33'h0;
         pact_r <= 33'h2;
         clk_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         pact_r <= pact_nxt;
         clk_r <= clk_nxt;
      end
   end
   assign pdm_clk = clk_r;

   // Decimation counter counts whole bit-clock periods
   logic [6:0] dec_r, dec_nxt;
   logic dec_stb, pv1_r, pv2_r;
   always_comb begin
      dec_stb = 1'b0;
      dec_nxt = dec_r;
      if (st_r == pdmr_pkg::PDMR_IDLE) begin
         dec_nxt = 7'h0;
      end else if (fall_ev) begin
         dec_nxt = dec_r + 7'h1;
         if (dec_r == (cfg_r.r80 ? pdmr_pkg::RATIO_HI
                                 : pdmr_pkg::RATIO_LO) - 7'h1) begin
            dec_nxt = 7'h0;
            dec_stb = 1'b1;
         end
      end
   end
   always_ff @(posedge clock) begin
      if (rst) begin
         dec_r <= 7'h0;
         pv1_r <= 1'b0;
         pv2_r <= 1'b0;
      end else begin
         dec_r <= dec_nxt;
         pv1_r <= dec_stb;
         pv2_r <= pv1_r;
      end
   end

   // Per-channel third-order filter and gain; channel 0 is left
   logic [15:0] pcm_r [2];
   logic [15:0] out_r [2];
   for (genvar c = 0; c < 2; c++) begin : g_ch
      logic signed [IW-1:0] in_r [3], in_nxt [3], z_r [3], z_nxt [3];
      logic signed [IW-1:0] y [3];
      logic [15:0] pcm_nxt, out_nxt;
      logic [19:0] gq;
      logic signed [33:0] prod;
      always_comb begin
         in_nxt = in_r;
         z_nxt = z_r;
         pcm_nxt = pcm_r[c];
         // Integrators run on this channel's edge
         if (st_r == pdmr_pkg::PDMR_IDLE) begin
            in_nxt = '{default: '0};
            z_nxt = '{default: '0};
         end else if (smp_ev[c]) begin
            in_nxt[0] = in_r[0] + (pdm_din ? IW'(1) : -IW'(1));
            in_nxt[1] = in_r[1] + in_nxt[0];
            in_nxt[2] = in_r[2] + in_nxt[1];
         end
         // Combs at the output rate, scaled to 16 bits
         y[0] = in_r[2] - z_r[0];
         y[1] = y[0] - z_r[1];
         y[2] = y[1] - z_r[2];
         if (dec_stb) begin
            z_nxt[0] = in_r[2];
            z_nxt[1] = y[0];
            z_nxt[2] = y[1];
            pcm_nxt = sat16(40'(y[2] >>> (cfg_r.r80 ? pdmr_pkg::SHIFT_HI
                                         : pdmr_pkg::SHIFT_LO)));
         end
         // Half-dB codes via octave and mantissa
         gq = gain_f(c == 0 ? cfg_r.gl : cfg_r.gr);
         prod = $signed(pcm_r[c]) * $signed({1'b0, gq[16:0]});
         out_nxt = pv1_r ? sat16(40'(prod >>> (pdmr_pkg::GAIN_SHIFT0
                                 - int'(gq[19:17])))) : out_r[c];
      end
      always_ff @(posedge clock) begin
         if (rst) begin
            in_r <= '{default: '0};
            z_r <= '{default: '0};
            pcm_r[c] <= 16'h0;
            out_r[c] <= 16'h0;
         end else begin
            in_r <= in_nxt;
            z_r <= z_nxt;
            pcm_r[c] <= pcm_nxt;
            out_r[c] <= out_nxt;
         end
      end
   end

   // Packing, memory writes and start/stop sequencing
   pdmr_pkg::pdmr_dma_t dma_r, dma_nxt;
   logic [31:0] cur_r, cur_nxt;
   logic [15:0] hold_r, hold_nxt, smp_r, smp_nxt;
   logic half_r, half_nxt, last_r, last_nxt, stop_r, stop_nxt;
   logic [31:0] word;
   logic done;
   always_comb begin
      st_nxt = st_r;
      cur_nxt = cur_r;
      hold_nxt = hold_r;
      smp_nxt = smp_r;
      half_nxt = half_r;
      last_nxt = last_r;
      stop_nxt = stop_r | tsk_stop;
      dma_nxt = dma_r;
      ev_set = 3'h0;
      done = dma_r.wr & ~dma_waitrequest;
      // Stereo {R,L}; mono {newer L, older L}
      // Lower address byte is the low sample byte
      word = cfg_r.mono ? {out_r[0], hold_r} : {out_r[1], out_r[0]};
      if (done) begin
         dma_nxt.wr = 1'b0;
      end
      case (st_r)
         pdmr_pkg::PDMR_IDLE: begin
            stop_nxt = 1'b0;
            if (tsk_start) begin
               st_nxt = pdmr_pkg::PDMR_RUN;
               cur_nxt = cfg_r.ptr;
               smp_nxt = 16'h0;
               half_nxt = 1'b0;
               ev_set[0] = 1'b1;
            end
         end
         pdmr_pkg::PDMR_RUN: begin
            if (pv2_r & ~dma_r.wr & ~stop_r) begin
               if (cfg_r.mono & ~half_r) begin
                  hold_nxt = out_r[0];
                  half_nxt = 1'b1;
               end else begin
                  half_nxt = 1'b0;
                  dma_nxt = '{addr: cur_r + {15'h0, smp_r, 1'b0},
                              data: word, wr: 1'b1};
                  smp_nxt = smp_r + 16'h2;
                  last_nxt = smp_nxt >= {1'b0, cfg_r.maxcnt};
               end
            end
            if (done & last_r) begin
               ev_set[2] = 1'b1;
               ev_set[0] = ~stop_r;
               cur_nxt = cfg_r.ptr;
               smp_nxt = 16'h0;
               last_nxt = 1'b0;
            end
            // Stop after the frame in flight
            // Stopped only once writes are done
            if (stop_r & (~dma_r.wr | done)) begin
               st_nxt = pdmr_pkg::PDMR_IDLE;
               ev_set[1] = 1'b1;
               // Final write after stop ends the buffer
               ev_set[2] = 1'b1;
               last_nxt = 1'b0;
            end
         end
         default: st_nxt = pdmr_pkg::PDMR_IDLE;
      endcase
   end

   // Sequencer registers
   always_ff @(posedge clock) begin
      if (rst) begin
         st_r <= pdmr_pkg::PDMR_IDLE;
         cur_r <= 32'h0;
         hold_r <= 16'h0;
         smp_r <= 16'h0;
         half_r <= 1'b0;
         last_r <= 1'b0;
         stop_r <= 1'b0;
         dma_r <= '0;
      end else begin
         st_r <= st_nxt;
         cur_r <= cur_nxt;
         hold_r <= hold_nxt;
         smp_r <= smp_nxt;
         half_r <= half_nxt;
         last_r <= last_nxt;
         stop_r <= stop_nxt;
         dma_r <= dma_nxt;
      end
   end
   assign dma_address = dma_r.addr;
   assign dma_writedata = dma_r.data;
   assign dma_write = dma_r.wr;
endmodule : pdmr_top

// ---- bench/pdmr_props.sv ----
// Port-level checks for the microphone receiver top.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ns
module pdmr_props #(
   parameter int IW = 24
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [11:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic peripheral_clock_32m_tick,
   input wire logic aclk_tick,
   input wire logic pdm_clk,
   input wire logic pdm_din,
   input wire logic [31:0] dma_address,
   input wire logic [31:0] dma_writedata,
   input wire logic dma_write,
   input wire logic dma_waitrequest
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // Set once software has issued a start; before that all is quiet
   logic run_r;
   logic run_nxt;
   // Next value: cleared by reset, set by an accepted start write
   always_comb begin
      run_nxt = run_r;
      if (rst) begin
         run_nxt = 1'b0;
      end else if (avs_write && !avs_waitrequest &&
                   avs_address == pdmr_pkg::OFS_START) begin
         run_nxt = 1'b1;
      end
   end
   // Register only
   always_ff @(posedge clock) begin
      run_r <= run_nxt;
   end
   // Bus request waiting for its answer
   sequence s_req;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   // Exactly one cycle of answer, then busy again
   sequence s_ack;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   a_bus_one_wait: assert property (s_req |=> s_ack)
      else $error("bus answer not one wait cycle");
   a_wait_has_req: assert property
      (!avs_waitrequest |-> (avs_read || avs_write))
      else $error("waitrequest low without a request");
   a_rdata_holds: assert property (!avs_read |-> $stable(avs_readdata))
      else $error("read data changed without a read");
   a_clk_on_tick: assert property
      ($rose(pdm_clk) |-> $past(peripheral_clock_32m_tick || aclk_tick))
      else $error("bit clock rose without a source tick");
   a_clk_idle_low: assert property (!run_r |-> !pdm_clk)
      else $error("bit clock active before start");
   a_dma_idle: assert property (!run_r |-> !dma_write)
      else $error("memory write before start");
   a_dma_hold: assert property (dma_write && dma_waitrequest |=>
      dma_write && $stable(dma_address) && $stable(dma_writedata))
      else $error("memory write dropped or changed in a stall");
   a_dma_release: assert property (dma_write && !dma_waitrequest |=>
      !dma_write)
      else $error("memory write not released after acceptance");
   a_dma_word: assert property (dma_write |->
      dma_address[1:0] == 2'h0)
      else $error("memory write address not word aligned");
endmodule : pdmr_props

bind pdmr_top pdmr_props #(.IW(IW)) i_props (.clock(clock), .rst(rst),
   .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .peripheral_clock_32m_tick(peripheral_clock_32m_tick),
   .aclk_tick(aclk_tick), .pdm_clk(pdm_clk), .pdm_din(pdm_din),
   .dma_address(dma_address), .dma_writedata(dma_writedata),
   .dma_write(dma_write), .dma_waitrequest(dma_waitrequest));

// ---- bench/pdmr_mic_pair.sv ----
// Behavioural pair of pulse-density microphones sharing one data line.
// Assumes the bit clock idles low; the bench sets each mic's bit level.
`timescale 1ns/1ns
module pdmr_mic_pair (
   input wire logic pdm_clk,
   input wire logic left_bit,
   input wire logic right_bit,
   output logic pdm_din
);
   // Left drives while high, right while low
   // One mic takes the line as the other lets go, so it never floats
   always_comb begin
      pdm_din = pdm_clk ? left_bit : right_bit;
   end
endmodule : pdmr_mic_pair

// ---- bench/pdm_microphone_receiver_tb.sv ----
// Self-checking bench for the pulse-density microphone receiver.
// Assumes the package, design, mic model and checker compile first.
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
   $display("ERROR %0t got %h exp %h", $time, (g), (e)); end end
module pdm_microphone_receiver_tb;
   logic clock, rst, avs_read, avs_write, peripheral_clock_32m_tick, aclk_tick;
   logic avs_waitrequest, pdm_clk, pdm_din, dma_write, dma_waitrequest;
   logic left_bit, right_bit;
   logic [11:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, dma_address, dma_writedata;
   logic [31:0] rdv; // Last read data
   int err_total, tests_run, cyc;
   logic [31:0] q_adr[$], q_dat[$]; // Words taken by the memory model
   // Reset value table, unmapped place last
   logic [11:0] ra[9] = '{pdmr_pkg::OFS_INC, pdmr_pkg::OFS_GAIN_L,
      pdmr_pkg::OFS_GAIN_R, pdmr_pkg::OFS_MODE, pdmr_pkg::OFS_RATIO,
      pdmr_pkg::OFS_MCLK, pdmr_pkg::OFS_PTR, pdmr_pkg::OFS_EV_END, 12'h7fc};
   logic [31:0] rv[9] = '{pdmr_pkg::RST_INC, 32'(pdmr_pkg::GAIN_DEF),
      32'(pdmr_pkg::GAIN_DEF), 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

   pdmr_top #(.IW(24)) i_dut (.clock(clock), .rst(rst),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .peripheral_clock_32m_tick(peripheral_clock_32m_tick),
      .aclk_tick(aclk_tick), .pdm_clk(pdm_clk), .pdm_din(pdm_din),
      .dma_address(dma_address), .dma_writedata(dma_writedata),
      .dma_write(dma_write), .dma_waitrequest(dma_waitrequest));
   pdmr_mic_pair i_mics (.pdm_clk(pdm_clk), .left_bit(left_bit),
      .right_bit(right_bit), .pdm_din(pdm_din));

   // 250 MHz system clock
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   // Ticks: 32M source every 2nd cycle, audio every 3rd; memory model
   always @(posedge clock) begin
      cyc <= cyc + 1;
      peripheral_clock_32m_tick <= (cyc % 2 == 0);
      aclk_tick <= (cyc % 3 == 0);
      // Random stalls keep the writer honest
      dma_waitrequest <= 1'($urandom_range(0, 1));
      if (dma_write === 1'b1 && dma_waitrequest === 1'b0) begin
         q_adr.push_back(dma_address);
         q_dat.push_back(dma_writedata);
      end
   end

   // One access; held until waitrequest is sampled low at an edge
   task automatic bus(input logic w, input logic [11:0] a,
         input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= ~w;
      do @(posedge clock); while (avs_waitrequest !== 1'b0);
      rdv = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clock);
   endtask : bus
   // Read a flag until bit 0 is set; the watchdog bounds it
   task automatic poll(input logic [11:0] a);
      rdv = 32'h0;
      while (rdv[0] !== 1'b1) bus(1'b0, a, 32'h0);
   endtask : poll
   // Bit clock period in system cycles, after a settling period
   task automatic period(input int exp_p);
      realtime t0;
      repeat (2) @(posedge pdm_clk);
      t0 = $realtime;
      @(posedge pdm_clk);
      `CHK(int'(($realtime - t0) / 4), exp_p)
   endtask : period
   // Stop, then the writer must be idle and the line quiet
   task automatic run_stop;
      int n;
      bus(1'b1, pdmr_pkg::OFS_EV_END, 32'h0);
      bus(1'b1, pdmr_pkg::OFS_STOP, 32'h1);
      poll(pdmr_pkg::OFS_EV_STOPPED);
      n = q_adr.size();
      `CHK(dma_write, 1'b0)
      bus(1'b0, pdmr_pkg::OFS_EV_END, 32'h0);
      `CHK(rdv[0], 1'b1)
      repeat (100) @(posedge clock);
      `CHK(pdm_clk, 1'b0)
      `CHK(q_adr.size(), n)
   endtask : run_stop
   // Buffer model: per words each buffer; first words are filter warm-up
   task automatic words(input logic [31:0] b0, b1, input int per,
         input logic [31:0] ew);
      logic [31:0] ea;
      for (int i = 0; i < q_adr.size(); i++) begin
         ea = ((i < per) ? b0 : b1) + 32'(4 * (i % per));
         `CHK(q_adr[i], ea)
         if (i >= 3) `CHK(q_dat[i], ew)
      end
   endtask : words
   // Verdict and end of run
   task automatic results;
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : results

   // Cut a hang short; the tests need about 17000 cycles
   initial begin
      #(4 * 80000);
      err_total++;
      results();
   end
   initial begin
      rdv = $urandom(37041);
      {rst, left_bit} = 2'b11;
      {avs_read, avs_write, right_bit, peripheral_clock_32m_tick, aclk_tick} = 5'h0;
      dma_waitrequest = 1'b1;
      avs_address = 12'h0;
      avs_writedata = 32'h0;
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      // Unmapped write is ignored; reset values read back
      bus(1'b1, 12'h7fc, 32'hffff_ffff);
      for (int i = 0; i < 9; i++) begin
         bus(1'b0, ra[i], 32'h0);
         `CHK(rdv, rv[i])
      end
      bus(1'b1, pdmr_pkg::OFS_GAIN_L, 32'(pdmr_pkg::GAIN_MAX));
      bus(1'b0, pdmr_pkg::OFS_GAIN_L, 32'h0);
      `CHK(rdv, 32'(pdmr_pkg::GAIN_MAX))
      bus(1'b1, pdmr_pkg::OFS_GAIN_L, 32'(pdmr_pkg::GAIN_DEF));
      // Stereo into two buffers of 4 words, bit period 4 ticks
      // Pointer in RAM and count, then start
      bus(1'b1, pdmr_pkg::OFS_INC, 32'h4000_0000);
      bus(1'b1, pdmr_pkg::OFS_PTR, 32'h0000_1000);
      bus(1'b1, pdmr_pkg::OFS_MAXCNT, 32'h8);
      bus(1'b1, pdmr_pkg::OFS_START, 32'h1);
      poll(pdmr_pkg::OFS_EV_STARTED);
      bus(1'b1, pdmr_pkg::OFS_EV_STARTED, 32'h0);
      bus(1'b1, pdmr_pkg::OFS_PTR, 32'h0000_2000);
      period(8);
      // Slower clock while running: 8 ticks
      bus(1'b1, pdmr_pkg::OFS_INC, 32'h2000_0000);
      repeat (50) @(posedge clock);
      period(16);
      while (q_adr.size() < 6) @(posedge clock);
      bus(1'b0, pdmr_pkg::OFS_EV_END, 32'h0);
      `CHK(rdv[0], 1'b1)
      bus(1'b0, pdmr_pkg::OFS_EV_STARTED, 32'h0);
      `CHK(rdv[0], 1'b1)
      run_stop();
      words(32'h1000, 32'h2000, 4, 32'h8000_7fff);
      // Mono, swapped, ratio 80, source set while stopped
      q_adr.delete();
      q_dat.delete();
      bus(1'b1, pdmr_pkg::OFS_MCLK, 32'h1);
      bus(1'b1, pdmr_pkg::OFS_MODE, 32'h3);
      bus(1'b1, pdmr_pkg::OFS_RATIO, 32'h1);
      // Left 12 codes down halves the level
      bus(1'b1, pdmr_pkg::OFS_GAIN_L, 32'(pdmr_pkg::GAIN_DEF) - 32'hc);
      bus(1'b1, pdmr_pkg::OFS_INC, 32'h4000_0000);
      bus(1'b1, pdmr_pkg::OFS_PTR, 32'h0000_3000);
      bus(1'b1, pdmr_pkg::OFS_MAXCNT, 32'h6);
      repeat (50) @(posedge clock); // New period settles first
      bus(1'b1, pdmr_pkg::OFS_START, 32'h1);
      period(12);
      while (q_adr.size() < 5) @(posedge clock);
      run_stop();
      words(32'h3000, 32'h3000, 3, 32'hc180_c180);
      results();
   end
endmodule : pdm_microphone_receiver_tb
